// >>> design/uemc_pkg.sv
// Constants for the uncore memory event monitor
package uemc_pkg;
  // Model-specific register index of the home logic matcher
  localparam logic [15:0] MATCH_MSR_ADDR = 16'h0396;
  localparam logic [63:0] MATCH_RESET = 64'h0000_0000_0000_0000;
  // Matcher field positions
  localparam int ADDR_LSB = 3;
  localparam int ADDR_MSB = 39;
  localparam int OPC_LSB = 40;
  localparam int OPC_MSB = 47;
  localparam int SEL_LSB = 61;
  localparam int SEL_MSB = 63;
  // Matcher select encodings
  localparam logic [2:0] SEL_AND = 3'h1;
  localparam logic [2:0] SEL_NONE = 3'h0;
  // Event codes
  localparam logic [7:0] EV_ISO_FULL = 8'h28;
  localparam logic [7:0] EV_BUSY = 8'h29;
  localparam logic [7:0] EV_NORM_OCC = 8'h2A;
  localparam logic [7:0] EV_ISO_OCC = 8'h2B;
  localparam logic [7:0] EV_NORM_RD = 8'h2C;
  localparam logic [7:0] EV_HIPRI_RD = 8'h2D;
  localparam logic [7:0] EV_CRIT_RD = 8'h2E;
  localparam logic [7:0] EV_WRITES = 8'h2F;
  localparam logic [7:0] EV_MATCH = 8'h35;
  localparam logic [7:0] EV_PG_OPEN = 8'h60;
  localparam logic [7:0] EV_PG_CLOSE = 8'h61;
  localparam logic [7:0] EV_PG_MISS = 8'h62;
  localparam logic [7:0] EV_CAS_RD = 8'h63;
  localparam logic [7:0] EV_CAS_WR = 8'h64;
  localparam logic [7:0] EV_REFRESH = 8'h65;
  localparam logic [7:0] EV_PRE_ALL = 8'h66;
  // Unit mask field positions: low group bits 2:0, high group bits 5:3
  localparam int UM_LO = 0;
  localparam int UM_HI = 3;
  localparam int NUM_CH = 3;
  localparam int CNT_W = 48;
  localparam logic [CNT_W-1:0] CNT_RESET = 48'h0000_0000_0000;
endpackage

// >>> design/uemc_matcher.sv
// Home logic address and opcode matcher with per-source hit pulses
`timescale 1ns/1ps
`default_nettype none
module uemc_matcher
  import uemc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Matcher register contents
  input wire logic [63:0] match_reg_i,
  // Incoming home logic request
  input wire logic req_valid_i,
  input wire logic [2:0] req_src_i,
  input wire logic [uemc_pkg::ADDR_MSB:0] req_addr_i,
  input wire logic [uemc_pkg::OPC_MSB-uemc_pkg::OPC_LSB:0] req_opcode_i,
  // Hit per source: bit 0 io hub, 1 remote, 2 local
  output logic [2:0] hit_o
);
  import uemc_pkg::*;

  logic [2:0] hit_ff;
  logic [2:0] nxt_hit;
  logic addr_eq;
  logic opc_eq;
  logic sel_hit;
  logic [2:0] sel;

  always_comb begin
    sel = match_reg_i[SEL_MSB:SEL_LSB];
    addr_eq = req_addr_i[ADDR_MSB:ADDR_LSB] == match_reg_i[ADDR_MSB:ADDR_LSB];
    opc_eq = req_opcode_i == match_reg_i[OPC_MSB:OPC_LSB];
    // Select decode; all zero gives no event at all
    case (sel[2:1])
      2'b10: sel_hit = addr_eq;
      2'b01: sel_hit = opc_eq;
      2'b11: sel_hit = addr_eq | opc_eq;
      default: sel_hit = (sel == SEL_AND) ? (addr_eq & opc_eq) : 1'b0;
    endcase
    nxt_hit = (req_valid_i && sel_hit) ? req_src_i : 3'h0;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hit_ff <= 3'h0;
    end else begin
      hit_ff <= nxt_hit;
    end
  end

  assign hit_o = hit_ff;
endmodule
`default_nettype wire

// >>> design/uemc_monitor.sv
// Memory controller and home logic event monitor top
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Each of three DRAM channels counted separately, with per-channel and any-channel masks.
// - Event 2A adds normal read queue occupancy, masks 01/02/04 pick channels.
// - Event 2C counts normal read inserts per channel; mask 07 all channels.
// - Event 2F masks 01/02/04 count full-line writes; 07 any channel.
// - Event 2F masks 08/10/20 count partial writes; 38 any channel.
// - Event 29 counts cycles busy with reads (01/02/04) or writes (08/10/20).
// - Events 60, 61, 62 count page open, close, miss per channel.
// - Event 2B adds isochronous read occupancy per channel or all with 07.
// - Events 2D and 2E count high and critical priority reads.
// - Event 28 counts cycles full with isochronous reads or writes.
// - Event 63 counts read CAS and read CAS auto-close, two bits per channel.
// - Event 64 counts write CAS and write CAS auto-close per channel.
// - Events 65 and 66 count refresh and precharge-all per channel.
// - Local miss goes to home logic and interconnect; remote data completes home.
// - Modified line from remote agent is written back to DRAM.
// - Remote load snoop hitting modified line: writeback first, then forward line.
// - Matcher holds address and opcode compare fields; equality makes a match.
// - Select bits 63:61 choose address, opcode, OR, AND or no event.
// - Reset clears matcher fields, disabling match event generation.
// - Event 35 counts matcher hits by source mask: io hub, remote, local.
module uemc_monitor
  import uemc_pkg::*;
#(
  parameter int OCC_W = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Model-specific register access
  input wire logic msr_wr_i,
  input wire logic msr_rd_i,
  input wire logic [15:0] msr_addr_i,
  input wire logic [63:0] msr_wdata_i,
  output logic [63:0] msr_rdata_o,
  // Counter control
  input wire logic count_en_i,
  input wire logic count_clr_i,
  input wire logic [7:0] evt_code_i,
  input wire logic [7:0] unit_mask_i,
  output logic [uemc_pkg::CNT_W-1:0] count_o,
  // Per-channel queue state
  input wire logic [OCC_W-1:0] norm_occ_i [uemc_pkg::NUM_CH],
  input wire logic [OCC_W-1:0] iso_occ_i [uemc_pkg::NUM_CH],
  input wire logic [2:0] norm_rd_ins_i,
  input wire logic [2:0] full_wr_i,
  input wire logic [2:0] part_wr_i,
  input wire logic [2:0] busy_rd_i,
  input wire logic [2:0] busy_wr_i,
  input wire logic [2:0] hipri_rd_i,
  input wire logic [2:0] crit_rd_i,
  input wire logic [2:0] iso_full_rd_i,
  input wire logic [2:0] iso_full_wr_i,
  // Per-channel DRAM commands
  input wire logic [2:0] pg_open_i,
  input wire logic [2:0] pg_close_i,
  input wire logic [2:0] pg_miss_i,
  input wire logic [2:0] cas_rd_i,
  input wire logic [2:0] cas_rd_ap_i,
  input wire logic [2:0] cas_wr_i,
  input wire logic [2:0] cas_wr_ap_i,
  input wire logic [2:0] refresh_i,
  input wire logic [2:0] pre_all_i,
  // Home logic request for the matcher
  input wire logic req_valid_i,
  input wire logic [2:0] req_src_i,
  input wire logic [uemc_pkg::ADDR_MSB:0] req_addr_i,
  input wire logic [uemc_pkg::OPC_MSB-uemc_pkg::OPC_LSB:0] req_opcode_i,
  // Miss and snoop flow
  input wire logic llc_miss_local_i,
  input wire logic remote_data_i,
  input wire logic remote_modified_i,
  input wire logic snp_load_hitm_i,
  input wire logic wb_done_i,
  output logic home_req_o,
  output logic link_req_o,
  output logic home_cmpl_o,
  output logic dram_wb_o,
  output logic snp_wb_o,
  output logic fwd_line_o,
  output logic snp_busy_o
);
  import uemc_pkg::*;

  localparam int INC_W = OCC_W + 2;

  typedef enum logic [1:0] {
    SNP_IDLE = 2'b00,
    SNP_WB = 2'b01,
    SNP_FWD = 2'b10
  } uemc_snp_e;

  // Counts set bits of a channel vector gated by a 3-bit mask
  function automatic logic [INC_W-1:0] mask_cnt(input logic [2:0] ev, input logic [2:0] um);
    logic [INC_W-1:0] s;
    s = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      s = s + INC_W'(ev[c] & um[c]);
    end
    return s;
  endfunction

  // Unit mask pairs for CAS events: bit 2c plain, bit 2c+1 auto-close
  function automatic logic [INC_W-1:0] pair_cnt(input logic [2:0] a, input logic [2:0] b,
                                                input logic [7:0] um);
    logic [INC_W-1:0] s;
    s = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      s = s + INC_W'(a[c] & um[2*c]) + INC_W'(b[c] & um[2*c+1]);
    end
    return s;
  endfunction

  // Sums occupancy over the channels enabled in the mask
  function automatic logic [INC_W-1:0] occ_sum(input logic [OCC_W-1:0] o [NUM_CH], input logic [2:0] um);
    logic [INC_W-1:0] s;
    s = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      s = s + (um[c] ? INC_W'(o[c]) : INC_W'(0));
    end
    return s;
  endfunction

  // True when a register access targets the matcher
  function automatic logic is_match_addr(input logic [15:0] a);
    return a == MATCH_MSR_ADDR;
  endfunction

  // Matcher register
  logic [63:0] match_ff;
  logic [63:0] nxt_match;
  logic [63:0] rdata_ff;
  logic [63:0] nxt_rdata;
  logic [2:0] hit;

  always_comb begin
    nxt_match = match_ff;
    nxt_rdata = rdata_ff;
    if (msr_wr_i && is_match_addr(msr_addr_i)) begin
      nxt_match = msr_wdata_i;
    end
    if (msr_rd_i) begin
      nxt_rdata = is_match_addr(msr_addr_i) ? match_ff : 64'h0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      match_ff <= MATCH_RESET;
      rdata_ff <= 64'h0;
    end else begin
      match_ff <= nxt_match;
      rdata_ff <= nxt_rdata;
    end
  end

  uemc_matcher u_matcher (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .match_reg_i(match_ff),
    .req_valid_i(req_valid_i),
    .req_src_i(req_src_i),
    .req_addr_i(req_addr_i),
    .req_opcode_i(req_opcode_i),
    .hit_o(hit)
  );

  // Event selection and counter
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [INC_W-1:0] inc;
  logic [2:0] um_lo;
  logic [2:0] um_hi;

  always_comb begin
    um_lo = unit_mask_i[UM_LO+2:UM_LO];
    um_hi = unit_mask_i[UM_HI+2:UM_HI];
    case (evt_code_i)
      EV_NORM_OCC: inc = occ_sum(norm_occ_i, um_lo);
      EV_ISO_OCC: inc = occ_sum(iso_occ_i, um_lo);
      EV_NORM_RD: inc = mask_cnt(norm_rd_ins_i, um_lo);
      EV_WRITES: inc = mask_cnt(full_wr_i, um_lo) + mask_cnt(part_wr_i, um_hi);
      EV_BUSY: inc = mask_cnt(busy_rd_i, um_lo) + mask_cnt(busy_wr_i, um_hi);
      EV_PG_OPEN: inc = mask_cnt(pg_open_i, um_lo);
      EV_PG_CLOSE: inc = mask_cnt(pg_close_i, um_lo);
      EV_PG_MISS: inc = mask_cnt(pg_miss_i, um_lo);
      EV_HIPRI_RD: inc = mask_cnt(hipri_rd_i, um_lo);
      EV_CRIT_RD: inc = mask_cnt(crit_rd_i, um_lo);
      EV_ISO_FULL: inc = mask_cnt(iso_full_rd_i, um_lo) + mask_cnt(iso_full_wr_i, um_hi);
      EV_CAS_RD: inc = pair_cnt(cas_rd_i, cas_rd_ap_i, unit_mask_i);
      EV_CAS_WR: inc = pair_cnt(cas_wr_i, cas_wr_ap_i, unit_mask_i);
      EV_REFRESH: inc = mask_cnt(refresh_i, um_lo);
      EV_PRE_ALL: inc = mask_cnt(pre_all_i, um_lo);
      EV_MATCH: inc = mask_cnt(hit, um_lo);
      default: inc = '0;
    endcase
    nxt_cnt = cnt_ff;
    if (count_clr_i) begin
      nxt_cnt = CNT_RESET;
    end else if (count_en_i) begin
      nxt_cnt = cnt_ff + CNT_W'(inc);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= CNT_RESET;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Miss and snoop flow
  uemc_snp_e snp_ff;
  uemc_snp_e nxt_snp;
  logic home_req_ff;
  logic nxt_home_req;
  logic link_req_ff;
  logic nxt_link_req;
  logic home_cmpl_ff;
  logic nxt_home_cmpl;
  logic dram_wb_ff;
  logic nxt_dram_wb;
  logic snp_wb_ff;
  logic nxt_snp_wb;
  logic fwd_ff;
  logic nxt_fwd;
  // Busy follows the next state so the port leaves its own flop
  logic snp_busy_ff;
  logic nxt_snp_busy;

  always_comb begin
    nxt_home_req = llc_miss_local_i;
    nxt_link_req = llc_miss_local_i;
    nxt_home_cmpl = remote_data_i;
    nxt_dram_wb = remote_data_i & remote_modified_i;
    nxt_snp = snp_ff;
    nxt_snp_wb = 1'b0;
    nxt_fwd = 1'b0;
    case (snp_ff)
      SNP_IDLE: begin
        if (snp_load_hitm_i) begin
          nxt_snp = SNP_WB;
          nxt_snp_wb = 1'b1;
        end
      end
      SNP_WB: begin
        if (wb_done_i) begin
          nxt_snp = SNP_FWD;
          nxt_fwd = 1'b1;
        end
      end
      SNP_FWD: begin
        nxt_snp = SNP_IDLE;
      end
      default: begin
        nxt_snp = SNP_IDLE;
      end
    endcase
    nxt_snp_busy = nxt_snp != SNP_IDLE;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      snp_ff <= SNP_IDLE;
      home_req_ff <= 1'b0;
      link_req_ff <= 1'b0;
      home_cmpl_ff <= 1'b0;
      dram_wb_ff <= 1'b0;
      snp_wb_ff <= 1'b0;
      fwd_ff <= 1'b0;
      snp_busy_ff <= 1'b0;
    end else begin
      snp_ff <= nxt_snp;
      home_req_ff <= nxt_home_req;
      link_req_ff <= nxt_link_req;
      home_cmpl_ff <= nxt_home_cmpl;
      dram_wb_ff <= nxt_dram_wb;
      snp_wb_ff <= nxt_snp_wb;
      fwd_ff <= nxt_fwd;
      snp_busy_ff <= nxt_snp_busy;
    end
  end

  assign msr_rdata_o = rdata_ff;
  assign count_o = cnt_ff;
  assign home_req_o = home_req_ff;
  assign link_req_o = link_req_ff;
  assign home_cmpl_o = home_cmpl_ff;
  assign dram_wb_o = dram_wb_ff;
  assign snp_wb_o = snp_wb_ff;
  assign fwd_line_o = fwd_ff;
  assign snp_busy_o = snp_busy_ff;
endmodule
`default_nettype wire

// >>> bench/uemc_checker.sv
// Assertion checker for the memory event monitor
`timescale 1ns/1ps
`default_nettype none
module uemc_checker
  import uemc_pkg::*;
(
  // Clock, reset and register access
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic msr_wr_i,
  input wire logic msr_rd_i,
  input wire logic [15:0] msr_addr_i,
  input wire logic [63:0] msr_wdata_i,
  input wire logic [63:0] msr_rdata_o,
  // Counter
  input wire logic count_en_i,
  input wire logic count_clr_i,
  input wire logic [CNT_W-1:0] count_o,
  // Miss and snoop flow
  input wire logic llc_miss_local_i,
  input wire logic remote_data_i,
  input wire logic remote_modified_i,
  input wire logic snp_load_hitm_i,
  input wire logic wb_done_i,
  input wire logic home_req_o,
  input wire logic link_req_o,
  input wire logic home_cmpl_o,
  input wire logic dram_wb_o,
  input wire logic snp_wb_o,
  input wire logic fwd_line_o,
  input wire logic snp_busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_MISS_FANOUT: assert property (llc_miss_local_i |=> home_req_o && link_req_o)
    else $error("miss not sent to both paths");
  AST_REMOTE_CMPL: assert property (remote_data_i |=>
    home_cmpl_o && dram_wb_o == $past(remote_modified_i))
    else $error("remote completion or writeback wrong");
  AST_SNP_START: assert property (snp_load_hitm_i && !snp_busy_o |=> snp_wb_o && snp_busy_o)
    else $error("snoop writeback not started");
  AST_SNP_FWD: assert property (snp_busy_o && wb_done_i && !fwd_line_o |=> fwd_line_o ##1 !snp_busy_o)
    else $error("forward did not follow writeback");
  AST_FWD_CAUSE: assert property (fwd_line_o |-> $past(wb_done_i) && $past(snp_busy_o))
    else $error("forward without writeback");
  AST_BUSY_HOLD: assert property (snp_busy_o && !fwd_line_o && !wb_done_i |=> snp_busy_o)
    else $error("busy dropped early");
  AST_CNT_CLR: assert property (count_clr_i |=> count_o == CNT_RESET)
    else $error("counter not cleared");
  AST_CNT_HOLD: assert property (!count_en_i && !count_clr_i |=> $stable(count_o))
    else $error("counter moved while disabled");
  AST_MSR_READ: assert property (msr_wr_i && msr_addr_i == MATCH_MSR_ADDR ##1 !msr_wr_i ##1
    msr_rd_i && !msr_wr_i && msr_addr_i == MATCH_MSR_ADDR |=> msr_rdata_o == $past(msr_wdata_i, 3))
    else $error("matcher readback wrong");
  AST_MSR_UNMAP: assert property (msr_rd_i && msr_addr_i != MATCH_MSR_ADDR |=> msr_rdata_o == 64'h0)
    else $error("unmapped read not zero");
endmodule
bind uemc_monitor uemc_checker uemc_checker_i (.clk_i(clk_i), .rst_i(rst_i), .msr_wr_i(msr_wr_i),
  .msr_rd_i(msr_rd_i), .msr_addr_i(msr_addr_i), .msr_wdata_i(msr_wdata_i), .msr_rdata_o(msr_rdata_o),
  .count_en_i(count_en_i), .count_clr_i(count_clr_i), .count_o(count_o), .llc_miss_local_i(llc_miss_local_i),
  .remote_data_i(remote_data_i), .remote_modified_i(remote_modified_i), .snp_load_hitm_i(snp_load_hitm_i),
  .wb_done_i(wb_done_i), .home_req_o(home_req_o), .link_req_o(link_req_o), .home_cmpl_o(home_cmpl_o),
  .dram_wb_o(dram_wb_o), .snp_wb_o(snp_wb_o), .fwd_line_o(fwd_line_o), .snp_busy_o(snp_busy_o));
`default_nettype wire

// >>> bench/uemc_dram_side.sv
// Far-side model that completes snoop writebacks after a set delay
`timescale 1ns/1ps
`default_nettype none
module uemc_dram_side (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic snp_wb_i,
  input wire logic [3:0] dly_i,
  output logic wb_done_o
);
  int cnt;
  always @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt = -1;
      wb_done_o <= 1'b0;
    end else begin
      if (snp_wb_i) cnt = dly_i;
      wb_done_o <= cnt == 0;
      if (cnt >= 0) cnt--;
    end
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the memory event monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uemc_pkg::*;
  logic clk_i = 0, rst_i = 1, msr_wr_i = 0, msr_rd_i = 0, count_en_i = 0, count_clr_i = 0;
  logic [15:0] msr_addr_i = '0;
  logic [63:0] msr_wdata_i = '0, msr_rdata_o, mreg, e_rd;
  logic [7:0] evt_code_i = '0, unit_mask_i = '0, req_opcode_i;
  logic [CNT_W-1:0] count_o, exp_cnt;
  logic [5:0] norm_occ_i [NUM_CH], iso_occ_i [NUM_CH];
  logic [2:0] norm_rd_ins_i, full_wr_i, part_wr_i, busy_rd_i, busy_wr_i, hipri_rd_i, crit_rd_i;
  logic [2:0] iso_full_rd_i, iso_full_wr_i, pg_open_i, pg_close_i, pg_miss_i, cas_rd_i, cas_rd_ap_i;
  logic [2:0] cas_wr_i, cas_wr_ap_i, refresh_i, pre_all_i, req_src_i, hitq;
  logic [39:0] req_addr_i;
  logic req_valid_i, llc_miss_local_i, remote_data_i, remote_modified_i, snp_load_hitm_i, wb_done_i;
  logic home_req_o, link_req_o, home_cmpl_o, dram_wb_o, snp_wb_o, fwd_line_o, snp_busy_o;
  logic [6:0] e_fl;
  logic [3:0] dly;
  int failures, checks_done, st;
  logic [7:0] codes [17] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h60, 8'h61,
    8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h35, 8'h71};
  logic [7:0] masks [9] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h08, 8'h10, 8'h20, 8'h38, 8'h3F};
  logic [63:0] opv [3] = '{64'h4000190000000000, 64'h40001A0000000000, 64'h40001D0000000000};
  uemc_monitor uemc_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .msr_wr_i(msr_wr_i), .msr_rd_i(msr_rd_i),
    .msr_addr_i(msr_addr_i), .msr_wdata_i(msr_wdata_i), .msr_rdata_o(msr_rdata_o), .count_en_i(count_en_i),
    .count_clr_i(count_clr_i), .evt_code_i(evt_code_i), .unit_mask_i(unit_mask_i), .count_o(count_o),
    .norm_occ_i(norm_occ_i), .iso_occ_i(iso_occ_i), .norm_rd_ins_i(norm_rd_ins_i), .full_wr_i(full_wr_i),
    .part_wr_i(part_wr_i), .busy_rd_i(busy_rd_i), .busy_wr_i(busy_wr_i), .hipri_rd_i(hipri_rd_i),
    .crit_rd_i(crit_rd_i), .iso_full_rd_i(iso_full_rd_i), .iso_full_wr_i(iso_full_wr_i), .pg_open_i(pg_open_i),
    .pg_close_i(pg_close_i), .pg_miss_i(pg_miss_i), .cas_rd_i(cas_rd_i), .cas_rd_ap_i(cas_rd_ap_i),
    .cas_wr_i(cas_wr_i), .cas_wr_ap_i(cas_wr_ap_i), .refresh_i(refresh_i), .pre_all_i(pre_all_i),
    .req_valid_i(req_valid_i), .req_src_i(req_src_i), .req_addr_i(req_addr_i), .req_opcode_i(req_opcode_i),
    .llc_miss_local_i(llc_miss_local_i), .remote_data_i(remote_data_i), .remote_modified_i(remote_modified_i),
    .snp_load_hitm_i(snp_load_hitm_i), .wb_done_i(wb_done_i), .home_req_o(home_req_o), .link_req_o(link_req_o),
    .home_cmpl_o(home_cmpl_o), .dram_wb_o(dram_wb_o), .snp_wb_o(snp_wb_o), .fwd_line_o(fwd_line_o),
    .snp_busy_o(snp_busy_o));
  uemc_dram_side uemc_dram_side_i (.clk_i(clk_i), .rst_i(rst_i), .snp_wb_i(snp_wb_o), .dly_i(dly),
    .wb_done_o(wb_done_i));
  wire logic [6:0] seen_fl = {home_req_o, link_req_o, home_cmpl_o, dram_wb_o, snp_wb_o, fwd_line_o, snp_busy_o};
  initial forever #25 clk_i = ~clk_i;
  function automatic logic hit();
    logic a, o;
    a = req_addr_i[39:3] == mreg[39:3];
    o = req_opcode_i == mreg[47:40];
    case (mreg[63:61])
      3'h4, 3'h5: return a;
      3'h2, 3'h3: return o;
      3'h6, 3'h7: return a | o;
      3'h1: return a & o;
      default: return 1'b0;
    endcase
  endfunction
  function automatic int incr();
    logic [2:0] lo, hi;
    int s;
    lo = unit_mask_i[2:0];
    hi = unit_mask_i[5:3];
    s = 0;
    case (evt_code_i)
      8'h2A: for (int c = 0; c < 3; c++) if (lo[c]) s += norm_occ_i[c];
      8'h2B: for (int c = 0; c < 3; c++) if (lo[c]) s += iso_occ_i[c];
      8'h2C: s = $countones(norm_rd_ins_i & lo);
      8'h2D: s = $countones(hipri_rd_i & lo);
      8'h2E: s = $countones(crit_rd_i & lo);
      8'h2F: s = $countones(full_wr_i & lo) + $countones(part_wr_i & hi);
      8'h29: s = $countones(busy_rd_i & lo) + $countones(busy_wr_i & hi);
      8'h28: s = $countones(iso_full_rd_i & lo) + $countones(iso_full_wr_i & hi);
      8'h60: s = $countones(pg_open_i & lo);
      8'h61: s = $countones(pg_close_i & lo);
      8'h62: s = $countones(pg_miss_i & lo);
      8'h63: for (int c = 0; c < 3; c++)
          s += (cas_rd_i[c] & unit_mask_i[2*c]) + (cas_rd_ap_i[c] & unit_mask_i[2*c+1]);
      8'h64: for (int c = 0; c < 3; c++)
          s += (cas_wr_i[c] & unit_mask_i[2*c]) + (cas_wr_ap_i[c] & unit_mask_i[2*c+1]);
      8'h65: s = $countones(refresh_i & lo);
      8'h66: s = $countones(pre_all_i & lo);
      8'h35: s = $countones(hitq & lo);
      default: s = 0;
    endcase
    return s;
  endfunction
  task automatic cmp(string n, logic [63:0] e, logic [63:0] g);
    checks_done++;
    if (e !== g) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic drive();
    {norm_rd_ins_i, full_wr_i, part_wr_i, busy_rd_i, busy_wr_i, hipri_rd_i} = 18'($urandom);
    {crit_rd_i, iso_full_rd_i, iso_full_wr_i, pg_open_i, pg_close_i, pg_miss_i} = 18'($urandom);
    {cas_rd_i, cas_rd_ap_i, cas_wr_i, cas_wr_ap_i, refresh_i, pre_all_i} = 18'($urandom);
    for (int c = 0; c < 3; c++) {norm_occ_i[c], iso_occ_i[c]} = 12'($urandom);
    {llc_miss_local_i, remote_data_i, remote_modified_i, snp_load_hitm_i, req_valid_i} = 5'($urandom);
    req_src_i = 3'h1 << ($urandom % 3);
    req_addr_i = ($urandom % 2) ? {mreg[39:3], 3'($urandom)} : 40'({$urandom, $urandom});
    req_opcode_i = ($urandom % 2) ? mreg[47:40] : 8'($urandom);
    count_en_i = ($urandom % 8) != 0;
    dly = 4'($urandom % 6);
  endtask
  task automatic step();
    @(posedge clk_i);
    if (count_clr_i) exp_cnt = '0;
    else if (count_en_i) exp_cnt += 48'(incr());
    hitq = (req_valid_i && hit()) ? req_src_i : 3'h0;
    if (msr_rd_i) e_rd = (msr_addr_i == 16'h0396) ? mreg : 64'h0;
    if (msr_wr_i && msr_addr_i == 16'h0396) mreg = msr_wdata_i;
    e_fl = {llc_miss_local_i, llc_miss_local_i, remote_data_i, remote_data_i & remote_modified_i,
      st == 0 && snp_load_hitm_i, st == 1 && wb_done_i, 1'b0};
    st = (st == 0) ? (snp_load_hitm_i ? 1 : 0) : (st == 1) ? (wb_done_i ? 2 : 1) : 0;
    e_fl[0] = st != 0;
    @(negedge clk_i);
    cmp("count", 64'(exp_cnt), 64'(count_o));
    cmp("rdata", e_rd, msr_rdata_o);
    cmp("flow", 64'(e_fl), 64'(seen_fl));
    drive();
  endtask
  task automatic msr(logic wr, logic [15:0] a, logic [63:0] d);
    msr_wr_i = wr;
    msr_rd_i = !wr;
    msr_addr_i = a;
    msr_wdata_i = d;
    step();
    msr_wr_i = 0;
    msr_rd_i = 0;
    step();
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(17));
    {failures, checks_done, st} = '0;
    {mreg, e_rd, exp_cnt, hitq} = '0;
    drive();
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 0;
    msr(0, 16'h0396, 64'h0);
    msr(1, 16'h0396, {$urandom, $urandom});
    msr(0, 16'h0396, 64'h0);
    msr(1, 16'h0395, 64'hFFFF_FFFF_FFFF_FFFF);
    msr(0, 16'h0395, 64'h0);
    msr(0, 16'h0396, 64'h0);
    foreach (codes[i]) foreach (masks[j]) begin
      evt_code_i = codes[i];
      unit_mask_i = masks[j];
      count_clr_i = 1;
      step();
      count_clr_i = 0;
      repeat (8) step();
    end
    evt_code_i = 8'h35;
    unit_mask_i = 8'h07;
    for (int i = 0; i < 11; i++) begin
      msr(1, 16'h0396, (i < 8) ? {3'(i), 29'($urandom), $urandom} : opv[i-8]);
      repeat (12) step();
    end
    // Mid-run reset must clear a loaded matcher and the counter
    msr(1, 16'h0396, {$urandom, $urandom});
    rst_i = 1;
    {mreg, e_rd, exp_cnt, hitq} = '0;
    st = 0;
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    msr(0, 16'h0396, 64'h0);
    repeat (4) step();
    tally_and_finish();
  end
  initial begin
    #(10000 * 50);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
